// >>> inc/dbw_params.svh
// Constants of the debug break and watch unit.
// Operation
// - Three-bit cause code records interrupt origin
// - Two-bit trigger index, zero for host/call
// - Simultaneous triggers of one kind report the lowest index
// - Eight-bit thread number, zero for host
// - Data watch hit stores effective address
// - Resource watch hit stores resource identifier
// - Stop vector halts threads outside debug mode
// - Eight scratch words shared with tile space
// - Four instruction breakpoint addresses compare PC
// - Per-thread enable byte, resets to zero
// - Condition bit selects equal or unequal PC
// - Per-entry enable clear blocks that entry's trigger; host and call requests still fire
// - Two address banks for data watchpoints
// - Load bit adds loads to data watch
// - Combine bit selects AND or OR
// - Resource watch mask and value banks
// - Resource select bit picks condition A/B
`ifndef DBW_PARAMS_SVH
`define DBW_PARAMS_SVH
`define DBW_OFS_CAUSE      8'h15
`define DBW_OFS_DATA       8'h16
`define DBW_OFS_STOP       8'h18
`define DBW_OFS_SCRATCH    8'h20
`define DBW_OFS_IB_ADDR    8'h30
`define DBW_OFS_IB_CTL     8'h40
`define DBW_OFS_DW_ADDR1   8'h50
`define DBW_OFS_DW_ADDR2   8'h60
`define DBW_OFS_DW_CTL     8'h70
`define DBW_OFS_RW_MASK    8'h80
`define DBW_OFS_RW_VALUE   8'h90
`define DBW_OFS_RW_CTL     8'h9c
`define DBW_CFG_SCRATCH    8'h20
`define DBW_BIT_EN         0
`define DBW_BIT_COND       1
`define DBW_BIT_LOAD       2
`define DBW_THR_LSB        16
`define DBW_IDX_LSB        16
`define DBW_TID_LSB        8
`define DBW_CAUSE_HOST     3'h1
`define DBW_CAUSE_CALL     3'h2
`define DBW_CAUSE_IBRK     3'h3
`define DBW_CAUSE_DWATCH   3'h4
`define DBW_CAUSE_RWATCH   3'h5
`endif

// >>> inc/dbw_pkg.sv
// Types of the debug break and watch unit.
package dbw_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } dbw_req_t;
    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] pc;
        logic        mem_valid;
        logic        mem_load;
        logic [31:0] eff_addr;
        logic        res_valid;
        logic [31:0] res_id;
    } dbw_pipe_t;
    typedef enum logic [0:0] {
        DBW_RUN   = 1'b0,
        DBW_DEBUG = 1'b1
    } dbw_state_t;
endpackage : dbw_pkg

// >>> rtl/dbw_top.sv
// Debug breakpoint, watchpoint and debug-interrupt unit of one tile.
`timescale 1ns/1ps
`include "dbw_params.svh"
module dbw_top
    import dbw_pkg::*;
#(
    parameter int NBP = 4
) (
    input  wire logic        CORE_CLK,
    input  wire logic        NRST,
    input  wire dbw_req_t    PS_REQ,
    output logic [31:0]      PS_RDATA,
    output logic             PS_RVALID,
    input  wire dbw_req_t    CFG_REQ,
    output logic [31:0]      CFG_RDATA,
    output logic             CFG_RVALID,
    input  wire dbw_pipe_t   PIPE,
    input  wire logic        HOST_REQ,
    input  wire logic        CALL_REQ,
    input  wire logic [2:0]  CALL_THREAD,
    input  wire logic        DEBUG_RETURN,
    output logic             DEBUG_IRQ,
    output logic             DEBUG_MODE,
    output logic [7:0]       THREAD_HALT
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    dbw_state_t  state;
    logic [2:0]  cause;
    logic [1:0]  bp_index;
    logic [7:0]  cause_thread;
    logic [31:0] irq_data;
    logic [7:0]  stop_mask;
    logic [31:0] scratch [8];
    logic [31:0] ib_addr [NBP];
    logic [9:0]  ib_ctl  [NBP];
    logic [31:0] dw_addr1[NBP];
    logic [31:0] dw_addr2[NBP];
    logic [10:0] dw_ctl  [NBP];
    logic [31:0] rw_mask [NBP];
    logic [31:0] rw_value[NBP];
    logic [9:0]  rw_ctl  [NBP];

    // Control words keep thread byte in [9:2], flags in [1:0] (data: [10:3], [2:0]).
    function automatic logic [1:0] lowest(input logic [3:0] hits);
        lowest = hits[0] ? 2'h0 : hits[1] ? 2'h1 : hits[2] ? 2'h2 : 2'h3;
    endfunction : lowest

    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        in_bank = (a >= base) && (a < base + 8'(NBP));
    endfunction : in_bank

    // ****************************************************************
    // Trigger detection
    // ****************************************************************
    logic [3:0] ib_hit;
    logic [3:0] dw_hit;
    logic [3:0] rw_hit;
    always_comb begin
        for (int i = 0; i < NBP; i++) begin
            logic a;
            logic b;
            a = 1'b0;
            b = 1'b0;
            ib_hit[i] = ib_ctl[i][`DBW_BIT_EN] && ib_ctl[i][2 + PIPE.thread] && PIPE.valid &&
                        ((PIPE.pc == ib_addr[i]) ^ ib_ctl[i][`DBW_BIT_COND]);
            a = PIPE.eff_addr == dw_addr1[i];
            b = PIPE.eff_addr == dw_addr2[i];
            dw_hit[i] = dw_ctl[i][`DBW_BIT_EN] && dw_ctl[i][3 + PIPE.thread] && PIPE.mem_valid &&
                        (!PIPE.mem_load || dw_ctl[i][`DBW_BIT_LOAD]) &&
                        (dw_ctl[i][`DBW_BIT_COND] ? (a || b) : (a && b));
            a = (PIPE.res_id & rw_mask[i]) == rw_value[i];
            rw_hit[i] = rw_ctl[i][`DBW_BIT_EN] && rw_ctl[i][2 + PIPE.thread] && PIPE.res_valid &&
                        (rw_ctl[i][`DBW_BIT_COND] ? !a : a);
        end
    end

    logic       run;
    logic       fire;
    assign run  = state == DBW_RUN;
    assign fire = run && (HOST_REQ || CALL_REQ || (|ib_hit) || (|dw_hit) || (|rw_hit));

    // ****************************************************************
    // Debug mode sequencing
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state     <= DBW_RUN;
            DEBUG_IRQ <= 1'b0;
        end else begin
            DEBUG_IRQ <= fire;
            case (state)
                DBW_RUN:   if (fire) state <= DBW_DEBUG;
                DBW_DEBUG: if (DEBUG_RETURN) state <= DBW_RUN;
                default:   state <= DBW_RUN;
            endcase
        end
    end
    assign DEBUG_MODE  = state == DBW_DEBUG;
    assign THREAD_HALT = run ? stop_mask : 8'h00;

    // ****************************************************************
    // Cause capture; hardware capture wins over a software write
    // ****************************************************************
    logic ps_wr_cause;
    logic ps_wr_data;
    assign ps_wr_cause = PS_REQ.wr && PS_REQ.addr == `DBW_OFS_CAUSE;
    assign ps_wr_data  = PS_REQ.wr && PS_REQ.addr == `DBW_OFS_DATA;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            cause        <= 3'h0;
            bp_index     <= 2'h0;
            cause_thread <= 8'h00;
        end else if (fire) begin
            if (HOST_REQ) begin
                cause        <= `DBW_CAUSE_HOST;
                bp_index     <= 2'h0;
                cause_thread <= 8'h00;
            end else if (CALL_REQ) begin
                cause        <= `DBW_CAUSE_CALL;
                bp_index     <= 2'h0;
                cause_thread <= {5'h00, CALL_THREAD};
            end else begin
                cause        <= (|ib_hit) ? `DBW_CAUSE_IBRK : (|dw_hit) ? `DBW_CAUSE_DWATCH : `DBW_CAUSE_RWATCH;
                bp_index     <= lowest((|ib_hit) ? ib_hit : (|dw_hit) ? dw_hit : rw_hit);
                cause_thread <= {5'h00, PIPE.thread};
            end
        end else if (ps_wr_cause) begin
            cause        <= PS_REQ.wdata[2:0];
            bp_index     <= PS_REQ.wdata[`DBW_IDX_LSB +: 2];
            cause_thread <= PS_REQ.wdata[`DBW_TID_LSB +: 8];
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_data <= 32'h0;
        end else if (fire && !HOST_REQ && !CALL_REQ && !(|ib_hit) && (|dw_hit)) begin
            irq_data <= PIPE.eff_addr;
        end else if (fire && !HOST_REQ && !CALL_REQ && !(|ib_hit) && (|rw_hit)) begin
            irq_data <= PIPE.res_id;
        end else if (ps_wr_data) begin
            irq_data <= PS_REQ.wdata;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            stop_mask <= 8'h00;
            for (int i = 0; i < NBP; i++) begin
                ib_addr[i]  <= 32'h0;
                ib_ctl[i]   <= 10'h000;
                dw_addr1[i] <= 32'h0;
                dw_addr2[i] <= 32'h0;
                dw_ctl[i]   <= 11'h000;
                rw_mask[i]  <= 32'h0;
                rw_value[i] <= 32'h0;
                rw_ctl[i]   <= 10'h000;
            end
        end else if (PS_REQ.wr) begin
            if (PS_REQ.addr == `DBW_OFS_STOP) stop_mask <= PS_REQ.wdata[7:0];
            for (int i = 0; i < NBP; i++) begin
                if (PS_REQ.addr == `DBW_OFS_IB_ADDR + 8'(i)) ib_addr[i] <= PS_REQ.wdata;
                if (PS_REQ.addr == `DBW_OFS_IB_CTL + 8'(i))
                    ib_ctl[i] <= {PS_REQ.wdata[`DBW_THR_LSB +: 8], PS_REQ.wdata[1:0]};
                if (PS_REQ.addr == `DBW_OFS_DW_ADDR1 + 8'(i)) dw_addr1[i] <= PS_REQ.wdata;
                if (PS_REQ.addr == `DBW_OFS_DW_ADDR2 + 8'(i)) dw_addr2[i] <= PS_REQ.wdata;
                if (PS_REQ.addr == `DBW_OFS_DW_CTL + 8'(i))
                    dw_ctl[i] <= {PS_REQ.wdata[`DBW_THR_LSB +: 8], PS_REQ.wdata[2:0]};
                if (PS_REQ.addr == `DBW_OFS_RW_MASK + 8'(i)) rw_mask[i] <= PS_REQ.wdata;
                if (PS_REQ.addr == `DBW_OFS_RW_VALUE + 8'(i)) rw_value[i] <= PS_REQ.wdata;
                if (PS_REQ.addr == `DBW_OFS_RW_CTL + 8'(i))
                    rw_ctl[i] <= {PS_REQ.wdata[`DBW_THR_LSB +: 8], PS_REQ.wdata[1:0]};
            end
        end
    end

    // Both ports reach one scratch array; the status port wins a same-word clash.
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < 8; i++) scratch[i] <= 32'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (PS_REQ.wr && PS_REQ.addr == `DBW_OFS_SCRATCH + 8'(i))
                    scratch[i] <= PS_REQ.wdata;
                else if (CFG_REQ.wr && CFG_REQ.addr == `DBW_CFG_SCRATCH + 8'(i))
                    scratch[i] <= CFG_REQ.wdata;
            end
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    logic [31:0] next_ps_rdata;
    logic [31:0] next_cfg_rdata;
    always_comb begin
        logic [1:0] k;
        k = PS_REQ.addr[1:0];
        next_ps_rdata = 32'h0;
        if (PS_REQ.addr == `DBW_OFS_CAUSE)
            next_ps_rdata = {14'h0, bp_index, cause_thread, 5'h00, cause};
        else if (PS_REQ.addr == `DBW_OFS_DATA) next_ps_rdata = irq_data;
        else if (PS_REQ.addr == `DBW_OFS_STOP) next_ps_rdata = {24'h0, stop_mask};
        else if (PS_REQ.addr[7:3] == 5'(`DBW_OFS_SCRATCH >> 3)) next_ps_rdata = scratch[PS_REQ.addr[2:0]];
        else if (in_bank(PS_REQ.addr, `DBW_OFS_IB_ADDR)) next_ps_rdata = ib_addr[k];
        else if (in_bank(PS_REQ.addr, `DBW_OFS_IB_CTL))
            next_ps_rdata = {8'h0, ib_ctl[k][9:2], 14'h0, ib_ctl[k][1:0]};
        else if (in_bank(PS_REQ.addr, `DBW_OFS_DW_ADDR1)) next_ps_rdata = dw_addr1[k];
        else if (in_bank(PS_REQ.addr, `DBW_OFS_DW_ADDR2)) next_ps_rdata = dw_addr2[k];
        else if (in_bank(PS_REQ.addr, `DBW_OFS_DW_CTL))
            next_ps_rdata = {8'h0, dw_ctl[k][10:3], 13'h0, dw_ctl[k][2:0]};
        else if (in_bank(PS_REQ.addr, `DBW_OFS_RW_MASK)) next_ps_rdata = rw_mask[k];
        else if (in_bank(PS_REQ.addr, `DBW_OFS_RW_VALUE)) next_ps_rdata = rw_value[k];
        else if (in_bank(PS_REQ.addr, `DBW_OFS_RW_CTL))
            next_ps_rdata = {8'h0, rw_ctl[k][9:2], 14'h0, rw_ctl[k][1:0]};
        next_cfg_rdata = (CFG_REQ.addr[7:3] == 5'(`DBW_CFG_SCRATCH >> 3)) ? scratch[CFG_REQ.addr[2:0]] : 32'h0;
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            PS_RDATA   <= 32'h0;
            PS_RVALID  <= 1'b0;
            CFG_RDATA  <= 32'h0;
            CFG_RVALID <= 1'b0;
        end else begin
            PS_RVALID  <= PS_REQ.rd;
            CFG_RVALID <= CFG_REQ.rd;
            if (PS_REQ.rd) PS_RDATA <= next_ps_rdata;
            if (CFG_REQ.rd) CFG_RDATA <= next_cfg_rdata;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_host_cause: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (run && HOST_REQ) |=> (cause == `DBW_CAUSE_HOST && DEBUG_IRQ)) else $error("host cause wrong");
    a_call_index: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (run && !HOST_REQ && CALL_REQ) |=> (bp_index == 2'h0 && cause == `DBW_CAUSE_CALL)) else $error("call index");
    a_lowest_index: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (run && !HOST_REQ && !CALL_REQ && ib_hit[0] && ib_hit[1]) |=> bp_index == 2'h0) else $error("not lowest");
    a_host_thread: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (run && HOST_REQ) |=> cause_thread == 8'h00) else $error("host thread nonzero");
    a_dwatch_data: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (run && !HOST_REQ && !CALL_REQ && ib_hit == 4'h0 && dw_hit != 4'h0)
        |=> (irq_data == $past(PIPE.eff_addr) && cause == `DBW_CAUSE_DWATCH)) else $error("data watch data");
    a_rwatch_data: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (fire && !HOST_REQ && !CALL_REQ && ib_hit == 4'h0 && dw_hit == 4'h0)
        |=> (irq_data == $past(PIPE.res_id))) else $error("resource watch data");
    a_halt_run: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        DEBUG_MODE |-> THREAD_HALT == 8'h00) else $error("halt during debug");
    a_scratch_share: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (PS_REQ.wr && PS_REQ.addr == `DBW_OFS_SCRATCH && !CFG_REQ.wr)
        ##1 (!PS_REQ.wr && !CFG_REQ.wr)
        ##1 (!PS_REQ.wr && !CFG_REQ.wr && CFG_REQ.rd && CFG_REQ.addr == `DBW_CFG_SCRATCH)
        |=> CFG_RDATA == $past(PS_REQ.wdata, 3)) else $error("scratch not shared");
    a_enable_gate: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !ib_ctl[0][`DBW_BIT_EN] |-> !ib_hit[0]) else $error("disabled breakpoint fired");
    a_debug_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (DEBUG_MODE && !DEBUG_RETURN) |=> (DEBUG_MODE && !DEBUG_IRQ)) else $error("debug mode left early");
endmodule : dbw_top

// >>> dv/dbw_core_model.sv
// Behavioural model of the core pipeline and the debug host around the unit.
`timescale 1ns/1ps
module dbw_core_model
    import dbw_pkg::*;
(
    input  wire logic       CORE_CLK,
    output dbw_pipe_t       PIPE,
    output logic            HOST_REQ,
    output logic            CALL_REQ,
    output logic [2:0]      CALL_THREAD,
    output logic            DEBUG_RETURN
);
    initial begin
        PIPE = '0;
        HOST_REQ = 1'b0;
        CALL_REQ = 1'b0;
        CALL_THREAD = 3'h0;
        DEBUG_RETURN = 1'b0;
    end
    // ***********************************************
    // Issue slots
    // ***********************************************
    // Kind 0 issues a PC, kind 1 a memory access, kind 2 a resource access, each for one cycle.
    task automatic issue(input logic [2:0] thr, input logic [1:0] kind, input logic load, input logic [31:0] val);
        dbw_pipe_t p;
        p = '0;
        p.valid = 1'b1;
        p.thread = thr;
        p.pc = (kind == 2'h0) ? val : 32'hffff_fff0;
        p.mem_valid = (kind == 2'h1);
        p.mem_load = load;
        p.eff_addr = val;
        p.res_valid = (kind == 2'h2);
        p.res_id = val;
        @(posedge CORE_CLK);
        #1;
        PIPE = p;
        @(posedge CORE_CLK);
        #1;
        // Idle fields show the inverse so stale values never pose as a match.
        PIPE = ~p;
        PIPE.valid = 1'b0;
        PIPE.mem_valid = 1'b0;
        PIPE.res_valid = 1'b0;
    endtask : issue
    // Which 0 is a host request, 1 a debug-call instruction, 2 a return from debug mode.
    task automatic pulse(input logic [1:0] which, input logic [2:0] thr);
        @(posedge CORE_CLK);
        #1;
        HOST_REQ = (which == 2'h0);
        CALL_REQ = (which == 2'h1);
        CALL_THREAD = thr;
        DEBUG_RETURN = (which == 2'h2);
        @(posedge CORE_CLK);
        #1;
        HOST_REQ = 1'b0;
        CALL_REQ = 1'b0;
        CALL_THREAD = ~thr;
        DEBUG_RETURN = 1'b0;
    endtask : pulse
endmodule : dbw_core_model

// >>> dv/debug_break_watch_unit_test.sv
// Self-checking testbench of the debug break and watch unit.
`timescale 1ns/1ps
module debug_break_watch_unit_test;
    import dbw_pkg::*;
    logic        core_clk;
    logic        nrst;
    dbw_req_t    ps_req;
    dbw_req_t    cfg_req;
    logic [31:0] ps_rdata;
    logic [31:0] cfg_rdata;
    logic        ps_rvalid;
    logic        cfg_rvalid;
    dbw_pipe_t   pipe;
    logic        host_req;
    logic        call_req;
    logic [2:0]  call_thread;
    logic        debug_return;
    logic        debug_irq;
    logic        debug_mode;
    logic [7:0]  thread_halt;
    int          mismatches = 0;
    int          checks_done = 0;
    dbw_top i_dbw_top (.CORE_CLK(core_clk), .NRST(nrst), .PS_REQ(ps_req), .PS_RDATA(ps_rdata),
        .PS_RVALID(ps_rvalid), .CFG_REQ(cfg_req), .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid),
        .PIPE(pipe), .HOST_REQ(host_req), .CALL_REQ(call_req), .CALL_THREAD(call_thread),
        .DEBUG_RETURN(debug_return), .DEBUG_IRQ(debug_irq), .DEBUG_MODE(debug_mode), .THREAD_HALT(thread_halt));
    dbw_core_model i_dbw_core_model (.CORE_CLK(core_clk), .PIPE(pipe), .HOST_REQ(host_req),
        .CALL_REQ(call_req), .CALL_THREAD(call_thread), .DEBUG_RETURN(debug_return));
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;
    // ***********************************************
    // Access and comparison tasks
    // ***********************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic cfg, input logic wr, input logic [7:0] a, input logic [31:0] d);
        dbw_req_t r;
        r = '0;
        r.addr = a;
        r.wr = wr;
        r.rd = ~wr;
        r.wdata = d;
        @(posedge core_clk);
        #1;
        if (cfg) cfg_req = r;
        else ps_req = r;
        @(posedge core_clk);
        #1;
        ps_req = '0;
        cfg_req = '0;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b0, 1'b1, a, d);
    endtask : wr
    task automatic rd(input logic cfg, input logic [7:0] a, input logic [31:0] exp);
        acc(cfg, 1'b0, a, 32'h0);
        check({31'h0, cfg ? cfg_rvalid : ps_rvalid}, 32'h1);
        check(cfg ? cfg_rdata : ps_rdata, exp);
    endtask : rd
    // Checks debug mode, the captured cause and data, then returns to run mode.
    task automatic capture(input logic [31:0] cause, input logic [31:0] data);
        check({31'h0, debug_mode}, 32'h1);
        check({24'h0, thread_halt}, 32'h0);
        rd(1'b0, 8'h15, cause);
        rd(1'b0, 8'h16, data);
        i_dbw_core_model.pulse(2'h2, 3'h0);
        check({31'h0, debug_mode}, 32'h0);
    endtask : capture
    // Checks the interrupt pulse and, when one is expected, the capture.
    task automatic irq(input logic exp, input logic [31:0] cause, input logic [31:0] data);
        check({31'h0, debug_irq}, {31'h0, exp});
        if (exp) begin
            capture(cause, data);
        end
    endtask : irq
    task automatic complete_run;
        if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        #200us;
        mismatches++;
        complete_run();
    end
    // ***********************************************
    // Test sequence
    // ***********************************************
    initial begin
        nrst = 1'b0;
        ps_req = '0;
        cfg_req = '0;
        repeat (3) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        rd(1'b0, 8'h40, 32'h0);
        rd(1'b0, 8'h73, 32'h0);
        rd(1'b0, 8'h9f, 32'h0);
        rd(1'b0, 8'h15, 32'h0);
        wr(8'h20, 32'hc0de_0001);
        rd(1'b1, 8'h20, 32'hc0de_0001);
        acc(1'b1, 1'b1, 8'h27, 32'h5a5a_a5a5);
        rd(1'b0, 8'h27, 32'h5a5a_a5a5);
        rd(1'b1, 8'h30, 32'h0);
        rd(1'b0, 8'hff, 32'h0);
        wr(8'h31, 32'h0000_0100);
        wr(8'h41, 32'h0004_0001);
        i_dbw_core_model.issue(3'h1, 2'h0, 1'b0, 32'h0000_0100);
        irq(1'b0, 32'h0, 32'h0);
        i_dbw_core_model.issue(3'h2, 2'h0, 1'b0, 32'h0000_0100);
        irq(1'b1, 32'h0001_0203, 32'h0);
        wr(8'h30, 32'h0000_0100);
        wr(8'h40, 32'h00ff_0001);
        i_dbw_core_model.issue(3'h2, 2'h0, 1'b0, 32'h0000_0100);
        irq(1'b1, 32'h0000_0203, 32'h0);
        wr(8'h40, 32'h00ff_0000);
        wr(8'h41, 32'h00ff_0003);
        i_dbw_core_model.issue(3'h3, 2'h0, 1'b0, 32'h0000_0100);
        irq(1'b0, 32'h0, 32'h0);
        i_dbw_core_model.issue(3'h3, 2'h0, 1'b0, 32'h0000_0104);
        irq(1'b1, 32'h0001_0303, 32'h0);
        wr(8'h41, 32'h00ff_0002);
        i_dbw_core_model.issue(3'h3, 2'h0, 1'b0, 32'h0000_0104);
        irq(1'b0, 32'h0, 32'h0);
        wr(8'h52, 32'h0000_2000);
        wr(8'h62, 32'h0000_3000);
        wr(8'h72, 32'h00ff_0001);
        i_dbw_core_model.issue(3'h4, 2'h1, 1'b0, 32'h0000_3000);
        irq(1'b0, 32'h0, 32'h0);
        wr(8'h72, 32'h00ff_0003);
        i_dbw_core_model.issue(3'h4, 2'h1, 1'b0, 32'h0000_3000);
        irq(1'b1, 32'h0002_0404, 32'h0000_3000);
        i_dbw_core_model.issue(3'h4, 2'h1, 1'b1, 32'h0000_2000);
        irq(1'b0, 32'h0, 32'h0);
        wr(8'h72, 32'h00ff_0007);
        i_dbw_core_model.issue(3'h5, 2'h1, 1'b1, 32'h0000_2000);
        irq(1'b1, 32'h0002_0504, 32'h0000_2000);
        wr(8'h72, 32'h0);
        wr(8'h83, 32'h0000_ff00);
        wr(8'h93, 32'h0000_1200);
        wr(8'h9f, 32'h0080_0001);
        i_dbw_core_model.issue(3'h7, 2'h2, 1'b0, 32'h0000_12ab);
        irq(1'b1, 32'h0003_0705, 32'h0000_12ab);
        wr(8'h9f, 32'h0080_0003);
        i_dbw_core_model.issue(3'h7, 2'h2, 1'b0, 32'h0000_12ab);
        irq(1'b0, 32'h0, 32'h0);
        i_dbw_core_model.issue(3'h7, 2'h2, 1'b0, 32'h0000_13ab);
        irq(1'b1, 32'h0003_0705, 32'h0000_13ab);
        wr(8'h9f, 32'h0);
        wr(8'h18, 32'hffff_ff5a);
        rd(1'b0, 8'h18, 32'h0000_005a);
        check({24'h0, thread_halt}, 32'h0000_005a);
        i_dbw_core_model.pulse(2'h0, 3'h6);
        check({31'h0, debug_irq}, 32'h1);
        i_dbw_core_model.pulse(2'h1, 3'h5);
        check({31'h0, debug_irq}, 32'h0);
        capture(32'h0000_0001, 32'h0000_13ab);
        check({24'h0, thread_halt}, 32'h0000_005a);
        i_dbw_core_model.pulse(2'h1, 3'h5);
        irq(1'b1, 32'h0000_0502, 32'h0000_13ab);
        complete_run();
    end
endmodule : debug_break_watch_unit_test
